/* File: logic/pccd_top.sv */
// Command decoder of the port controller with its register port
`timescale 1ns/1ps
`include "pccd_consts.svh"

module pccd_top (
  input wire logic mclk,
  input wire logic rst,
  input wire pccd_pkg::pccd_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] cc_line_one_role,
  input wire logic [1:0] cc_line_two_role,
  input wire logic goodcrc_sent,
  input wire logic tx_buf_loaded,
  input wire logic tx_byte_push,
  input wire logic rx_byte_pop,
  input wire logic iface_error_clr,
  output logic bus_presence_detect_enable,
  output logic bus_sourcing_on,
  output logic bus_level_programmed,
  output logic restart_attach_detection,
  output logic stop_rx_armed,
  output logic rx_detect_clear,
  output logic tx_pointer_rewind,
  output logic rx_pointer_rewind,
  output logic [7:0] tx_ptr,
  output logic [7:0] rx_ptr,
  output logic tx_buf_valid,
  output logic iface_error
);
  import pccd_pkg::*;

  // =====================================================================
  // Helpers

  // True when a request addresses a given register
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  pccd_state_s state_reg;
  pccd_state_s state_next;
  logic cmd_wr;
  logic ext_wr;
  logic roles_match;

  // Decoded write strobes; the alert register write is decoded only to be dropped
  assign cmd_wr = reg_req.wr && reg_hit(reg_req.addr, `PCCD_OFF_PORT_CMD);
  assign ext_wr = reg_req.wr && reg_hit(reg_req.addr, `PCCD_OFF_EXT_ALERT);
  assign roles_match = (cc_line_one_role == cc_line_two_role);

  // =====================================================================
  // Next-state logic
  // A command written at one edge is acted on at the following edge,
  // which also clears the register unless a new write lands in that cycle.
  always_comb
  begin
    state_next = state_reg;
    state_next.restart_pulse = 1'b0;
    state_next.rx_detect_clr = 1'b0;
    state_next.tx_rew_pulse = 1'b0;
    state_next.rx_rew_pulse = 1'b0;

    // Every mapped and unmapped read returns zero; the alert bits are reserved
    if (reg_req.rd)
    begin
      state_next.rdata = `PCCD_READ_ZERO;
    end

    // Buffer pointer movement from the buffer logic
    if (tx_byte_push)
    begin
      state_next.tx_ptr = state_reg.tx_ptr + 8'h01;
    end
    if (rx_byte_pop)
    begin
      state_next.rx_ptr = state_reg.rx_ptr + 8'h01;
    end
    if (tx_buf_loaded)
    begin
      state_next.tx_valid = 1'b1;
    end

    // Armed receive stop fires once on the next GoodCRC sent
    if (state_reg.rx_stop_armed && goodcrc_sent)
    begin
      state_next.rx_detect_clr = 1'b1;
      state_next.rx_stop_armed = 1'b0;
    end

    // Software clear of the error flag; a new error below overrides it
    if (iface_error_clr)
    begin
      state_next.iface_err = 1'b0;
    end

    // Act on the held command code
    unique case (state_reg.cmd)
      `PCCD_CMD_DETECT_OFF:
      begin
        if (state_reg.src_on)
        begin
          state_next.iface_err = 1'b1;
        end
        else
        begin
          state_next.det_en = 1'b0;
        end
      end
      `PCCD_CMD_DETECT_ON:
      begin
        state_next.det_en = 1'b1;
      end
      `PCCD_CMD_SRC_STOP:
      begin
        state_next.src_on = 1'b0;
        state_next.src_nondef = 1'b0;
      end
      `PCCD_CMD_SRC_DEFAULT:
      begin
        state_next.src_on = 1'b1;
        state_next.det_en = 1'b1;
        state_next.src_nondef = 1'b0;
      end
      `PCCD_CMD_SRC_PROGRAMMED:
      begin
        if (state_reg.src_on)
        begin
          state_next.src_nondef = 1'b1;
        end
        else
        begin
          state_next.iface_err = 1'b1;
        end
      end
      `PCCD_CMD_RESTART_ATTACH:
      begin
        // Mismatched roles leave detection untouched
        state_next.restart_pulse = roles_match;
      end
      `PCCD_CMD_STOP_RX_NEXT_ACK:
      begin
        state_next.rx_stop_armed = 1'b1;
      end
      `PCCD_CMD_TX_REWIND:
      begin
        state_next.tx_ptr = `PCCD_PTR_START;
        state_next.tx_valid = 1'b0;
        state_next.tx_rew_pulse = 1'b1;
      end
      `PCCD_CMD_RX_REWIND:
      begin
        state_next.rx_ptr = `PCCD_PTR_START;
        state_next.rx_rew_pulse = 1'b1;
      end
      `PCCD_CMD_SINK_OFF, `PCCD_CMD_SINK_ON:
      begin
        // Source-only port: accepted, nothing to do
        state_next.cmd = `PCCD_CMD_NONE;
      end
      default:
      begin
        // Idle code or an unknown one: no action
        state_next.cmd = `PCCD_CMD_NONE;
      end
    endcase

    // Clear after acting; a same-cycle write is kept so no command is lost
    state_next.cmd = `PCCD_CMD_NONE;
    if (cmd_wr)
    begin
      state_next.cmd = reg_req.wdata;
    end
    // Writes to the reserved alert register change nothing
    if (ext_wr)
    begin
      state_next.rdata = state_next.rdata;
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.cmd <= `PCCD_PORT_CMD_RESET;
      state_reg.rdata <= `PCCD_EXT_ALERT_RESET;
      state_reg.tx_ptr <= `PCCD_PTR_RESET;
      state_reg.rx_ptr <= `PCCD_PTR_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // =====================================================================
  // Outputs, all straight from flip-flops
  assign reg_rdata = state_reg.rdata;
  assign bus_presence_detect_enable = state_reg.det_en;
  assign bus_sourcing_on = state_reg.src_on;
  assign bus_level_programmed = state_reg.src_nondef;
  assign restart_attach_detection = state_reg.restart_pulse;
  assign stop_rx_armed = state_reg.rx_stop_armed;
  assign rx_detect_clear = state_reg.rx_detect_clr;
  assign tx_pointer_rewind = state_reg.tx_rew_pulse;
  assign rx_pointer_rewind = state_reg.rx_rew_pulse;
  assign tx_ptr = state_reg.tx_ptr;
  assign rx_ptr = state_reg.rx_ptr;
  assign tx_buf_valid = state_reg.tx_valid;
  assign iface_error = state_reg.iface_err;

  // =====================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Read of the alert register answers zero on the next edge
  property p_alert_reads_zero;
    reg_req.rd && reg_hit(reg_req.addr, `PCCD_OFF_EXT_ALERT) |=> reg_rdata == 8'h00;
  endproperty
  a_alert_reads_zero: assert property (p_alert_reads_zero) else $error("alert register read not zero");

  property p_alert_bits_zero;
    reg_req.rd && reg_hit(reg_req.addr, `PCCD_OFF_EXT_ALERT)
      |=> reg_rdata[`PCCD_BIT_SRC_FAST_SWAP:`PCCD_BIT_SNK_FAST_SWAP] == 2'b00;
  endproperty
  a_alert_bits_zero: assert property (p_alert_bits_zero) else $error("fast swap bits not zero");

  property p_alert_write_ignored;
    ext_wr && reg_req.wdata[`PCCD_BIT_SNK_FAST_SWAP] ##1 reg_req.rd |=> reg_rdata == 8'h00;
  endproperty
  a_alert_write_ignored: assert property (p_alert_write_ignored) else $error("alert write took effect");

  property p_cmd_cleared;
    cmd_wr ##1 !cmd_wr |=> state_reg.cmd == 8'h00;
  endproperty
  a_cmd_cleared: assert property (p_cmd_cleared) else $error("command not cleared");

  // A command acted on in the read cycle may raise the flag by itself, so only idle cycles count
  property p_cmd_read_zero;
    reg_req.rd && reg_hit(reg_req.addr, `PCCD_OFF_PORT_CMD) && !iface_error && state_reg.cmd == 8'h00
      |=> reg_rdata == 8'h00 && !iface_error;
  endproperty
  a_cmd_read_zero: assert property (p_cmd_read_zero) else $error("command read not zero");

  sequence s_write_code(logic [7:0] code);
    cmd_wr && reg_req.wdata == code;
  endsequence

  property p_detect_off;
    s_write_code(8'h22) ##0 !bus_sourcing_on ##1 !bus_sourcing_on |=> !bus_presence_detect_enable;
  endproperty
  a_detect_off: assert property (p_detect_off) else $error("detect off ignored");

  property p_detect_off_err;
    s_write_code(8'h22) ##0 bus_sourcing_on ##1 bus_sourcing_on
      |=> iface_error && bus_presence_detect_enable == $past(bus_presence_detect_enable);
  endproperty
  a_detect_off_err: assert property (p_detect_off_err) else $error("detect off while sourcing");

  property p_detect_on;
    s_write_code(8'h33) ##1 1'b1 |=> bus_presence_detect_enable;
  endproperty
  a_detect_on: assert property (p_detect_on) else $error("detect on ignored");

  property p_src_stop;
    s_write_code(8'h66) ##1 1'b1
      |=> !bus_sourcing_on && bus_presence_detect_enable == $past(bus_presence_detect_enable);
  endproperty
  a_src_stop: assert property (p_src_stop) else $error("stop sourcing wrong");

  property p_src_default;
    s_write_code(8'h77) ##1 1'b1 |=> bus_sourcing_on && bus_presence_detect_enable && !bus_level_programmed;
  endproperty
  a_src_default: assert property (p_src_default) else $error("default sourcing wrong");

  property p_programmed_err;
    s_write_code(8'h88) ##0 !bus_sourcing_on ##1 !bus_sourcing_on |=> iface_error && !bus_level_programmed;
  endproperty
  a_programmed_err: assert property (p_programmed_err) else $error("programmed level without sourcing");

  property p_programmed_ok;
    s_write_code(8'h88) ##0 bus_sourcing_on ##1 bus_sourcing_on |=> bus_level_programmed;
  endproperty
  a_programmed_ok: assert property (p_programmed_ok) else $error("programmed level not taken");

  property p_restart;
    s_write_code(8'h99) ##1 1'b1 |=> restart_attach_detection == $past(cc_line_one_role == cc_line_two_role);
  endproperty
  a_restart: assert property (p_restart) else $error("restart gating wrong");

  property p_rx_stop;
    stop_rx_armed && goodcrc_sent |=> rx_detect_clear;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("receive stop missed");

  property p_tx_rewind;
    s_write_code(8'hDD) ##1 !tx_byte_push |=> tx_ptr == 8'h01 && !tx_buf_valid && tx_pointer_rewind;
  endproperty
  a_tx_rewind: assert property (p_tx_rewind) else $error("transmit rewind wrong");

  property p_rx_rewind;
    s_write_code(8'hEE) ##1 !rx_byte_pop |=> rx_ptr == 8'h01 && rx_pointer_rewind;
  endproperty
  a_rx_rewind: assert property (p_rx_rewind) else $error("receive rewind wrong");

  property p_sink_noop;
    s_write_code(8'h44) ##1 1'b1 |=> $stable(bus_sourcing_on) && $stable(bus_presence_detect_enable);
  endproperty
  a_sink_noop: assert property (p_sink_noop) else $error("sink command acted");

  property p_unknown_noop;
    s_write_code(8'h13) ##1 !cmd_wr |=> state_reg.cmd == 8'h00 && $stable(bus_sourcing_on);
  endproperty
  a_unknown_noop: assert property (p_unknown_noop) else $error("unknown code acted");

  property p_sink_on_noop;
    s_write_code(8'h55) ##1 1'b1 |=> $stable(bus_sourcing_on) && $stable(bus_presence_detect_enable);
  endproperty
  a_sink_on_noop: assert property (p_sink_on_noop) else $error("sink on command acted");

  property p_rx_stop_armed;
    s_write_code(8'hAA) ##1 1'b1 |=> stop_rx_armed;
  endproperty
  a_rx_stop_armed: assert property (p_rx_stop_armed) else $error("receive stop not armed");

  // A re-arm acted on in the same cycle wins over the disarm
  property p_rx_stop_disarm;
    stop_rx_armed && goodcrc_sent && state_reg.cmd != 8'hAA |=> !stop_rx_armed;
  endproperty
  a_rx_stop_disarm: assert property (p_rx_stop_disarm) else $error("receive stop still armed");

  property p_no_early_clear;
    !stop_rx_armed |=> !rx_detect_clear;
  endproperty
  a_no_early_clear: assert property (p_no_early_clear) else $error("receive detect cleared unarmed");

  property p_err_sticky;
    iface_error && !iface_error_clr |=> iface_error;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped on its own");

  // Reset itself is checked here, so this one is never disabled
  property p_reset_state;
    disable iff (1'b0)
    rst |=> tx_ptr == 8'h01 && rx_ptr == 8'h01 && state_reg.cmd == 8'h00 && !iface_error;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

endmodule

/* File: logic/pccd_consts.svh */
// Constants for the port controller command decoder: offsets, fields, codes, reset values
// =====================================================================
// How it works
// - Timer-expired alert bit ignores writes, reads zero
// - Source fast-swap alert bit ignores writes, reads zero
// - Sink fast-swap alert bit ignores writes, reads zero
// - Command register resets zero, cleared after acting
// - Code 0x22 turns presence and safe-zero detect off
// - Code 0x33 turns presence and safe-zero detect on
// - Code 0x66 stops sourcing, detection left alone
// - Code 0x77 sources default level, enables detect
// - Code 0x77 returns non-default level to default
// - Code 0x88 targets programmed level, only while sourcing
// - Code 0x99 restarts attach detection if roles equal
// - Code 0xAA clears receive-detect after next GoodCRC
// - Code 0xDD rewinds transmit pointer, invalidates contents
// - Code 0xEE rewinds receive pointer to one
// - Sink commands accepted and do nothing
// - Code 0x88 while not sourcing flags interface error
// - Code 0x22 while sourcing flags interface error
// - Command register reads zero, raises no error
`ifndef PCCD_CONSTS_SVH
`define PCCD_CONSTS_SVH

// =====================================================================
// Register map
`define PCCD_OFF_EXT_ALERT 8'h21
`define PCCD_OFF_PORT_CMD 8'h23
`define PCCD_EXT_ALERT_RESET 8'h00
`define PCCD_PORT_CMD_RESET 8'h00
`define PCCD_READ_ZERO 8'h00

// =====================================================================
// Reserved alert field positions
`define PCCD_BIT_TIMER_EXPIRED 2
`define PCCD_BIT_SRC_FAST_SWAP 1
`define PCCD_BIT_SNK_FAST_SWAP 0

// =====================================================================
// Command codes
`define PCCD_CMD_NONE 8'h00
`define PCCD_CMD_DETECT_OFF 8'h22
`define PCCD_CMD_DETECT_ON 8'h33
`define PCCD_CMD_SINK_OFF 8'h44
`define PCCD_CMD_SINK_ON 8'h55
`define PCCD_CMD_SRC_STOP 8'h66
`define PCCD_CMD_SRC_DEFAULT 8'h77
`define PCCD_CMD_SRC_PROGRAMMED 8'h88
`define PCCD_CMD_RESTART_ATTACH 8'h99
`define PCCD_CMD_STOP_RX_NEXT_ACK 8'hAA
`define PCCD_CMD_TX_REWIND 8'hDD
`define PCCD_CMD_RX_REWIND 8'hEE

// =====================================================================
// Buffer pointer values
`define PCCD_PTR_START 8'h01
`define PCCD_PTR_RESET 8'h01

`endif

/* File: logic/pccd_pkg.sv */
// Types shared by the port controller command decoder
`include "pccd_consts.svh"

package pccd_pkg;

  // =====================================================================
  // Register access request from the controller interface
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pccd_reg_req_s;

  // =====================================================================
  // Complete state of the decoder
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] rdata;
    logic det_en;
    logic src_on;
    logic src_nondef;
    logic rx_stop_armed;
    logic iface_err;
    logic [7:0] tx_ptr;
    logic [7:0] rx_ptr;
    logic tx_valid;
    logic restart_pulse;
    logic rx_detect_clr;
    logic tx_rew_pulse;
    logic rx_rew_pulse;
  } pccd_state_s;

endpackage

/* File: test/pccd_mgr_model.sv */
// Port manager model that writes command codes and reads registers of the decoder
`timescale 1ns/1ps

module pccd_mgr_model (
  input wire logic mclk,
  output pccd_pkg::pccd_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  import pccd_pkg::*;

  // =====================================================================
  // Bus idle at time zero, no strobe raised
  initial reg_req = '0;

  // =====================================================================
  // Single-byte write; address and data are inverted on release so a stale value never looks live
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    reg_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    reg_req <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
  endtask

  // Single-byte read; data is taken one cycle after the strobe edge, where it is registered
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk);
    reg_req <= '{addr: addr, wdata: 8'hA5, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    reg_req <= '{addr: ~addr, wdata: 8'h5A, wr: 1'b0, rd: 1'b0};
    @(posedge mclk);
    #1;
    data = reg_rdata;
  endtask
endmodule

/* File: test/pccd_top_tb.sv */
// Self-checking testbench of the port controller command decoder
`timescale 1ns/1ps

module pccd_top_tb;
  import pccd_pkg::*;

  logic mclk;
  logic rst;
  pccd_reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic [1:0] cc_line_one_role;
  logic [1:0] cc_line_two_role;
  logic goodcrc_sent;
  logic tx_buf_loaded;
  logic tx_byte_push;
  logic rx_byte_pop;
  logic iface_error_clr;
  logic bus_presence_detect_enable;
  logic bus_sourcing_on;
  logic bus_level_programmed;
  logic restart_attach_detection;
  logic stop_rx_armed;
  logic rx_detect_clear;
  logic tx_pointer_rewind;
  logic rx_pointer_rewind;
  logic [7:0] tx_ptr;
  logic [7:0] rx_ptr;
  logic tx_buf_valid;
  logic iface_error;
  logic [7:0] rd;
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] noop_codes [4] = '{8'h44, 8'h55, 8'h13, 8'hFF};

  // =====================================================================
  // Design, and the port manager on its register side
  pccd_top uut (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .cc_line_one_role(cc_line_one_role), .cc_line_two_role(cc_line_two_role),
    .goodcrc_sent(goodcrc_sent), .tx_buf_loaded(tx_buf_loaded), .tx_byte_push(tx_byte_push),
    .rx_byte_pop(rx_byte_pop), .iface_error_clr(iface_error_clr),
    .bus_presence_detect_enable(bus_presence_detect_enable), .bus_sourcing_on(bus_sourcing_on),
    .bus_level_programmed(bus_level_programmed), .restart_attach_detection(restart_attach_detection),
    .stop_rx_armed(stop_rx_armed), .rx_detect_clear(rx_detect_clear),
    .tx_pointer_rewind(tx_pointer_rewind), .rx_pointer_rewind(rx_pointer_rewind),
    .tx_ptr(tx_ptr), .rx_ptr(rx_ptr), .tx_buf_valid(tx_buf_valid), .iface_error(iface_error));
  pccd_mgr_model mgr (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  // =====================================================================
  // Clock of 5 ns
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Levels packed: detect, sourcing, programmed, armed, tx valid, error
  function automatic logic [7:0] lv();
    return {2'b00, bus_presence_detect_enable, bus_sourcing_on, bus_level_programmed,
      stop_rx_armed, tx_buf_valid, iface_error};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Command write, then wait until the effect and any pulse are visible
  task automatic cmd(input logic [7:0] code);
    mgr.wr_reg(`PCCD_OFF_PORT_CMD, code);
    @(posedge mclk);
    #1;
  endtask

  task automatic clr_err();
    @(posedge mclk);
    iface_error_clr <= 1'b1;
    @(posedge mclk);
    iface_error_clr <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // =====================================================================
  // Watchdog: the sequence needs about 90 cycles, so 5000 means a hang
  initial
  begin
    #(5 * 5000);
    mismatches++;
    print_verdict();
  end

  // =====================================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {cc_line_one_role, cc_line_two_role} = 4'h5;
    {goodcrc_sent, tx_buf_loaded, tx_byte_push, rx_byte_pop, iface_error_clr} = '0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("levels", 8'h00, lv());
    chk("tx_ptr", `PCCD_PTR_RESET, tx_ptr);
    chk("rx_ptr", `PCCD_PTR_RESET, rx_ptr);
    mgr.rd_reg(`PCCD_OFF_PORT_CMD, rd);
    chk("cmd reset", `PCCD_PORT_CMD_RESET, rd);
    mgr.wr_reg(`PCCD_OFF_EXT_ALERT, 8'h07);
    mgr.rd_reg(`PCCD_OFF_EXT_ALERT, rd);
    chk("ext alert", 8'h00, rd);
    done("reset");
    // Programmed level refused while not sourcing
    cmd(`PCCD_CMD_SRC_PROGRAMMED);
    chk("prog idle", 8'h01, lv());
    clr_err();
    cmd(`PCCD_CMD_SRC_DEFAULT);
    chk("default", 8'h30, lv());
    mgr.rd_reg(`PCCD_OFF_PORT_CMD, rd);
    chk("cmd cleared", 8'h00, rd);
    chk("read no err", 8'h30, lv());
    cmd(`PCCD_CMD_SRC_PROGRAMMED);
    chk("programmed", 8'h38, lv());
    cmd(`PCCD_CMD_SRC_DEFAULT);
    chk("back default", 8'h30, lv());
    cmd(`PCCD_CMD_DETECT_OFF);
    chk("detect off src", 8'h31, lv());
    clr_err();
    cmd(`PCCD_CMD_SRC_STOP);
    chk("src stop", 8'h20, lv());
    cmd(`PCCD_CMD_DETECT_OFF);
    chk("detect off", 8'h00, lv());
    cmd(`PCCD_CMD_DETECT_ON);
    chk("detect on", 8'h20, lv());
    done("power");
    // Sink and unknown codes leave everything alone
    foreach (noop_codes[i])
    begin
      cmd(noop_codes[i]);
      chk("noop", 8'h20, lv());
    end
    mgr.rd_reg(`PCCD_OFF_PORT_CMD, rd);
    chk("noop cleared", 8'h00, rd);
    done("noop");
    cmd(`PCCD_CMD_RESTART_ATTACH);
    chk("restart equal", 8'h01, {7'h00, restart_attach_detection});
    @(posedge mclk);
    cc_line_two_role <= 2'h2;
    cmd(`PCCD_CMD_RESTART_ATTACH);
    chk("restart differ", 8'h00, {7'h00, restart_attach_detection});
    cmd(`PCCD_CMD_STOP_RX_NEXT_ACK);
    chk("armed", 8'h24, lv());
    chk("no early clear", 8'h00, {7'h00, rx_detect_clear});
    @(posedge mclk);
    goodcrc_sent <= 1'b1;
    @(posedge mclk);
    goodcrc_sent <= 1'b0;
    #1;
    chk("rx clear", 8'h01, {7'h00, rx_detect_clear});
    chk("disarmed", 8'h20, lv());
    done("attach rx");
    // Move both pointers, then rewind them
    @(posedge mclk);
    {tx_buf_loaded, tx_byte_push, rx_byte_pop} <= 3'b111;
    repeat (2) @(posedge mclk);
    {tx_buf_loaded, rx_byte_pop} <= 2'b00;
    @(posedge mclk);
    tx_byte_push <= 1'b0;
    @(posedge mclk);
    #1;
    chk("tx moved", 8'h04, tx_ptr);
    chk("rx moved", 8'h03, rx_ptr);
    cmd(`PCCD_CMD_TX_REWIND);
    chk("tx rewind", `PCCD_PTR_START, tx_ptr);
    chk("tx pulse", 8'h20, {2'b00, tx_pointer_rewind, tx_buf_valid, 4'h0});
    cmd(`PCCD_CMD_RX_REWIND);
    chk("rx rewind", `PCCD_PTR_RESET, rx_ptr);
    chk("rx pulse", 8'h01, {7'h00, rx_pointer_rewind});
    done("buffers");
    print_verdict();
  end
endmodule
